// ==== hdl/power_stage_map.svh ====
`ifndef POWER_STAGE_MAP_SVH
`define POWER_STAGE_MAP_SVH

// ----------------------------------------
// word layout
// ----------------------------------------
`define PAYLOAD_BITS        6
`define CURRENT_WORD_BITS   7
`define ERROR_WORD_BITS     6
`define CURRENT_START_VALUE 1'h1

// ----------------------------------------
// mode pin codes
// ----------------------------------------
`define MODE_CODE_BITS      2
`define MODE_REGULATION     2'h0
`define MODE_FAST_TRANSIENT 2'h1
`define MODE_OUTPUT_LIMIT   2'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS       10
`define BIT_CLOCK_DIVIDE    2
`define SYNC_STAGES         2
`define BUFFER_DEPTH        2

`endif

// ==== hdl/power_stage_pkg.sv ====
package power_stage_pkg;

`include "power_stage_map.svh"

    typedef struct packed {
        logic                     valid;
        logic [`PAYLOAD_BITS-1:0] code;
    } sample_t;

    typedef enum logic [1:0] {
        mode_regulation,
        mode_fast_transient,
        mode_output_limit
    } mode_t;

    typedef enum logic {
        tx_idle,
        tx_shift
    } tx_state_t;

endpackage

// ==== hdl/word_buffer.sv ====
`timescale 1ns/1ps

module word_buffer #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 2
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW:0]      count_reg;
    logic             push;
    logic             pop;

    assign o_in_ready  = (count_reg != (PW+1)'(DEPTH));
    assign o_out_valid = (count_reg != '0);
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem[rd_ptr_reg];

    // ----------------------------------------
    // storage
    // ----------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem[wr_ptr_reg] <= i_in_data;
        end
    end

    // ----------------------------------------
    // pointers and fill level
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// ==== hdl/serial_word_tx.sv ====
`timescale 1ns/1ps

module serial_word_tx #(
    parameter int WIDTH = 7
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_tick,
    input  wire logic             i_valid,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_frame_en,
    output logic                  o_ready,
    output logic                  o_serial,
    output logic                  o_frame,
    output logic                  o_busy
);
    localparam int CW = $clog2(WIDTH);

    power_stage_pkg::tx_state_t state_reg;
    logic [WIDTH-1:0]           shift_reg;
    logic [CW-1:0]              count_reg;

    // idle bit period between words keeps the frame edge visible
    assign o_ready = i_tick && (state_reg == power_stage_pkg::tx_idle);
    assign o_busy  = (state_reg == power_stage_pkg::tx_shift);

    // ----------------------------------------
    // shifter, one bit per tick, msb first
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_reg <= power_stage_pkg::tx_idle;
            shift_reg <= '0;
            count_reg <= '0;
            o_serial  <= 1'b0;
            o_frame   <= 1'b0;
        end
        else if (i_tick)
        begin
            case (state_reg)
                power_stage_pkg::tx_idle:
                begin
                    if (i_valid)
                    begin
                        o_serial  <= i_data[WIDTH-1];
                        o_frame   <= i_frame_en;
                        shift_reg <= i_data << 1;
                        count_reg <= CW'(WIDTH-1);
                        state_reg <= power_stage_pkg::tx_shift;
                    end
                end
                power_stage_pkg::tx_shift:
                begin
                    if (count_reg == '0)
                    begin
                        o_serial  <= 1'b0;
                        o_frame   <= 1'b0;
                        state_reg <= power_stage_pkg::tx_idle;
                    end
                    else
                    begin
                        o_serial  <= shift_reg[WIDTH-1];
                        shift_reg <= shift_reg << 1;
                        count_reg <= count_reg - 1'b1;
                    end
                end
                default:
                begin
                    state_reg <= power_stage_pkg::tx_idle;
                end
            endcase
        end
    end
endmodule

// ==== hdl/power_stage_digital_readout.sv ====
// Notes on behaviour
// - high-side switch on only while pulse-width input high and no fault
// - peak-current word: 7 bits, msb first, start bit one leads
// - current word payload is the sampled high-side peak current
// - error word: 6 bits, msb first, on the error serial output
// - error word is sensed voltage code minus target voltage code
// - in regulation mode the conversion strobe frames each error word
// - overshoot flag set while output spikes above programmed level
// - droop flag set while output droops below programmed level
// - sense path runs in exactly one of three modes chosen by controller
// - low-side gate follows the low-side drive input
`timescale 1ns/1ps
`include "power_stage_map.svh"

module power_stage_digital_readout (
    input  wire logic                            i_clk,
    input  wire logic                            i_reset_n,
    input  wire logic                            i_pulse_width_in,
    input  wire logic                            i_fault,
    input  wire logic                            i_low_side_drive_in,
    input  wire logic                            i_above_level,
    input  wire logic                            i_below_level,
    input  wire logic [`MODE_CODE_BITS-1:0]      i_mode_code,
    input  wire power_stage_pkg::sample_t        i_current_sample,
    output logic                                 o_current_sample_ready,
    input  wire power_stage_pkg::sample_t        i_sense_sample,
    input  wire logic [`PAYLOAD_BITS-1:0]        i_target_voltage_code,
    output logic                                 o_sense_sample_ready,
    output logic                                 o_high_side_on,
    output logic                                 o_low_side_gate_out,
    output logic                                 o_peak_current_serial_out,
    output logic                                 o_error_serial_out,
    output logic                                 o_conversion_strobe,
    output logic                                 o_overshoot_flag,
    output logic                                 o_droop_flag,
    output power_stage_pkg::mode_t               o_mode
);
    localparam int PINS = 5 + `MODE_CODE_BITS;

    logic [PINS-1:0]                 pin_raw;
    logic [PINS-1:0]                 pin_meta_reg;
    logic [PINS-1:0]                 pin_sync_reg;
    logic                            pwm_s;
    logic                            fault_s;
    logic                            drive_s;
    logic                            above_s;
    logic                            below_s;
    logic [`MODE_CODE_BITS-1:0]      mode_code_s;
    power_stage_pkg::mode_t          mode_reg;
    power_stage_pkg::mode_t          mode_next;
    logic                            bit_tick_reg;

    logic [`CURRENT_WORD_BITS-1:0]   cur_word;
    logic                            cur_buf_valid;
    logic [`CURRENT_WORD_BITS-1:0]   cur_buf_data;
    logic                            cur_tx_ready;
    logic                            cur_busy;

    logic [`ERROR_WORD_BITS-1:0]     err_word;
    logic                            err_buf_valid;
    logic [`ERROR_WORD_BITS-1:0]     err_buf_data;
    logic                            err_tx_ready;
    logic                            err_busy;
    logic                            err_frame_en;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    assign pin_raw = {i_mode_code, i_below_level, i_above_level,
                      i_low_side_drive_in, i_fault, i_pulse_width_in};

    generate
        for (genvar g = 0; g < PINS; g++)
        begin : g_sync
            always_ff @(posedge i_clk or negedge i_reset_n)
            begin
                if (!i_reset_n)
                begin
                    pin_meta_reg[g] <= 1'b0;
                    pin_sync_reg[g] <= 1'b0;
                end
                else
                begin
                    pin_meta_reg[g] <= pin_raw[g];
                    pin_sync_reg[g] <= pin_meta_reg[g];
                end
            end
        end
    endgenerate

    assign pwm_s       = pin_sync_reg[0];
    assign fault_s     = pin_sync_reg[1];
    assign drive_s     = pin_sync_reg[2];
    assign above_s     = pin_sync_reg[3];
    assign below_s     = pin_sync_reg[4];
    assign mode_code_s = pin_sync_reg[PINS-1:5];

    // ----------------------------------------
    // mode select
    // ----------------------------------------
    always_comb
    begin
        case (mode_code_s)
            `MODE_REGULATION:     mode_next = power_stage_pkg::mode_regulation;
            `MODE_FAST_TRANSIENT: mode_next = power_stage_pkg::mode_fast_transient;
            `MODE_OUTPUT_LIMIT:   mode_next = power_stage_pkg::mode_output_limit;
            default:              mode_next = mode_reg;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            mode_reg <= power_stage_pkg::mode_regulation;
        end
        else
        begin
            mode_reg <= mode_next;
        end
    end

    assign o_mode = mode_reg;

    // ----------------------------------------
    // bit clock divider
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            bit_tick_reg <= 1'b0;
        end
        else
        begin
            bit_tick_reg <= !bit_tick_reg;
        end
    end

    // ----------------------------------------
    // gate drive
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_high_side_on      <= 1'b0;
            o_low_side_gate_out <= 1'b0;
        end
        else
        begin
            o_high_side_on      <= pwm_s && !fault_s;
            o_low_side_gate_out <= drive_s;
        end
    end

    // ----------------------------------------
    // transient flags
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_overshoot_flag <= 1'b0;
            o_droop_flag     <= 1'b0;
        end
        else
        begin
            o_overshoot_flag <= above_s;
            o_droop_flag     <= below_s;
        end
    end

    // ----------------------------------------
    // peak current path
    // ----------------------------------------
    assign cur_word = {`CURRENT_START_VALUE, i_current_sample.code};

    word_buffer #(
        .WIDTH (`CURRENT_WORD_BITS),
        .DEPTH (`BUFFER_DEPTH)
    ) u_cur_buf (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_in_valid  (i_current_sample.valid),
        .i_in_data   (cur_word),
        .o_in_ready  (o_current_sample_ready),
        .o_out_valid (cur_buf_valid),
        .i_out_ready (cur_tx_ready),
        .o_out_data  (cur_buf_data)
    );

    serial_word_tx #(
        .WIDTH (`CURRENT_WORD_BITS)
    ) u_cur_tx (
        .i_clk      (i_clk),
        .i_reset_n  (i_reset_n),
        .i_tick     (bit_tick_reg),
        .i_valid    (cur_buf_valid),
        .i_data     (cur_buf_data),
        .i_frame_en (1'b0),
        .o_ready    (cur_tx_ready),
        .o_serial   (o_peak_current_serial_out),
        .o_frame    (),
        .o_busy     (cur_busy)
    );

    // ----------------------------------------
    // voltage error path
    // ----------------------------------------
    assign err_word     = i_sense_sample.code - i_target_voltage_code;
    assign err_frame_en = (mode_reg == power_stage_pkg::mode_regulation);

    word_buffer #(
        .WIDTH (`ERROR_WORD_BITS),
        .DEPTH (`BUFFER_DEPTH)
    ) u_err_buf (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_in_valid  (i_sense_sample.valid),
        .i_in_data   (err_word),
        .o_in_ready  (o_sense_sample_ready),
        .o_out_valid (err_buf_valid),
        .i_out_ready (err_tx_ready),
        .o_out_data  (err_buf_data)
    );

    serial_word_tx #(
        .WIDTH (`ERROR_WORD_BITS)
    ) u_err_tx (
        .i_clk      (i_clk),
        .i_reset_n  (i_reset_n),
        .i_tick     (bit_tick_reg),
        .i_valid    (err_buf_valid),
        .i_data     (err_buf_data),
        .i_frame_en (err_frame_en),
        .o_ready    (err_tx_ready),
        .o_serial   (o_error_serial_out),
        .o_frame    (o_conversion_strobe),
        .o_busy     (err_busy)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_cur_word;
        ##13 cur_busy ##1 !cur_busy;
    endsequence

    sequence s_err_word;
        ##11 err_busy ##1 !err_busy;
    endsequence

    a_high_side_pwm: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !i_pulse_width_in [*4] |-> !o_high_side_on)
        else $error("high side on without pulse-width input");

    a_high_side_fault: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_fault [*4] |-> !o_high_side_on)
        else $error("high side on during fault");

    a_low_side_follow: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_low_side_drive_in [*4] |-> o_low_side_gate_out)
        else $error("low side gate does not follow drive input");

    a_current_start_bit: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(cur_busy) |-> o_peak_current_serial_out ##1 o_peak_current_serial_out)
        else $error("current word lacks start bit");

    a_current_word_len: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(cur_busy) |-> s_cur_word)
        else $error("current word length wrong");

    a_error_word_len: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(err_busy) |-> s_err_word)
        else $error("error word length wrong");

    a_error_msb_first: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(err_busy) |-> o_error_serial_out == $past(err_buf_data[`ERROR_WORD_BITS-1]))
        else $error("error word msb not first");

    a_bit_period: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !$past(bit_tick_reg) |-> $stable(o_error_serial_out) && $stable(o_peak_current_serial_out))
        else $error("serial bit changed mid period");

    a_strobe_frames: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(err_busy) && $past(err_frame_en) |->
        o_conversion_strobe [*6] ##1 o_conversion_strobe [*6] ##1 !o_conversion_strobe)
        else $error("strobe does not frame error word");

    a_strobe_in_word: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_conversion_strobe |-> err_busy)
        else $error("strobe outside error word");

    a_overshoot_flag: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_above_level [*4] |-> o_overshoot_flag)
        else $error("overshoot flag missing");

    a_droop_flag: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !i_below_level [*4] |-> !o_droop_flag)
        else $error("droop flag without droop");
endmodule

// ==== bench/serial_word_receiver.sv ====
`timescale 1ns/1ps

module serial_word_receiver #(
    parameter int WIDTH     = 7,
    parameter bit USE_FRAME = 0
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_serial,
    input  wire logic             i_frame,
    output logic                  o_word_valid,
    output logic      [WIDTH-1:0] o_word,
    output logic                  o_len_valid,
    output logic      [7:0]       o_frame_len
);
    logic             busy_reg;
    logic             skip_reg;
    logic [3:0]       count_reg;
    logic [WIDTH-1:0] shift_reg;
    logic [7:0]       len_reg;
    logic             start;

    assign start = USE_FRAME ? i_frame : i_serial;

    // ----------------------------------------
    // word capture, one bit per two clocks
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            busy_reg     <= 1'b0;
            skip_reg     <= 1'b0;
            count_reg    <= 4'h0;
            shift_reg    <= '0;
            o_word_valid <= 1'b0;
            o_word       <= '0;
        end
        else
        begin
            o_word_valid <= 1'b0;
            if (!busy_reg)
            begin
                if (skip_reg)
                    skip_reg <= 1'b0;
                else if (start)
                begin
                    busy_reg  <= 1'b1;
                    skip_reg  <= 1'b1;
                    count_reg <= 4'h1;
                    shift_reg <= {{(WIDTH-1){1'b0}}, i_serial};
                end
            end
            else if (skip_reg)
                skip_reg <= 1'b0;
            else
            begin
                shift_reg <= {shift_reg[WIDTH-2:0], i_serial};
                skip_reg  <= 1'b1;
                count_reg <= count_reg + 4'h1;
                if (count_reg == 4'(WIDTH-1))
                begin
                    busy_reg     <= 1'b0;
                    o_word_valid <= 1'b1;
                    o_word       <= {shift_reg[WIDTH-2:0], i_serial};
                end
            end
        end
    end

    // ----------------------------------------
    // strobe length in clocks
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            len_reg     <= 8'h00;
            o_len_valid <= 1'b0;
            o_frame_len <= 8'h00;
        end
        else
        begin
            o_len_valid <= 1'b0;
            if (i_frame)
                len_reg <= len_reg + 8'h01;
            else if (len_reg != 8'h00)
            begin
                o_frame_len <= len_reg;
                o_len_valid <= 1'b1;
                len_reg     <= 8'h00;
            end
        end
    end
endmodule

// ==== bench/power_stage_digital_readout_tb.sv ====
`timescale 1ns/1ps
`include "power_stage_map.svh"

module power_stage_digital_readout_tb;
    localparam int TIMEOUT_CYCLES = 20000;
    logic                     i_clk;
    logic                     i_reset_n;
    logic [4:0]               pins;
    logic [1:0]               i_mode_code;
    power_stage_pkg::sample_t i_current_sample;
    power_stage_pkg::sample_t i_sense_sample;
    logic [5:0]               i_target_voltage_code;
    logic                     cur_ready;
    logic                     sense_ready;
    logic                     high_side;
    logic                     low_gate;
    logic                     cur_ser;
    logic                     err_ser;
    logic                     strobe;
    logic                     over_flag;
    logic                     droop_flag;
    power_stage_pkg::mode_t   mode;
    logic                     cur_v;
    logic [6:0]               cur_w;
    logic                     err_v;
    logic [5:0]               err_w;
    logic                     len_v;
    logic [7:0]               len_w;
    int                       errors;
    int                       n_compared;
    int                       cycles;
    int                       refused;
    logic [7:0]               cur_exp[$];
    logic [7:0]               err_exp[$];
    logic [7:0]               cur_got[$];
    logic [7:0]               err_got[$];
    logic [7:0]               len_got[$];

    power_stage_digital_readout dut_u (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_pulse_width_in(pins[4]),
        .i_fault(pins[3]), .i_low_side_drive_in(pins[2]), .i_above_level(pins[1]),
        .i_below_level(pins[0]), .i_mode_code(i_mode_code),
        .i_current_sample(i_current_sample), .o_current_sample_ready(cur_ready),
        .i_sense_sample(i_sense_sample), .i_target_voltage_code(i_target_voltage_code),
        .o_sense_sample_ready(sense_ready), .o_high_side_on(high_side),
        .o_low_side_gate_out(low_gate), .o_peak_current_serial_out(cur_ser),
        .o_error_serial_out(err_ser), .o_conversion_strobe(strobe),
        .o_overshoot_flag(over_flag), .o_droop_flag(droop_flag), .o_mode(mode));

    serial_word_receiver #(.WIDTH(7), .USE_FRAME(0)) cur_rx_u (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_serial(cur_ser), .i_frame(1'b0),
        .o_word_valid(cur_v), .o_word(cur_w), .o_len_valid(), .o_frame_len());
    serial_word_receiver #(.WIDTH(6), .USE_FRAME(1)) err_rx_u (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_serial(err_ser), .i_frame(strobe),
        .o_word_valid(err_v), .o_word(err_w), .o_len_valid(len_v), .o_frame_len(len_w));

    always #5 i_clk = ~i_clk;

    always @(negedge i_clk)
    begin
        if (cur_v === 1'b1) cur_got.push_back({1'b0, cur_w});
        if (err_v === 1'b1) err_got.push_back({2'b00, err_w});
        if (len_v === 1'b1) len_got.push_back(len_w);
    end

    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == TIMEOUT_CYCLES)
        begin
            errors++;
            end_of_test();
        end
    end

    task automatic check_bit(input string name, input logic exp, input logic got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic check_word(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic settle();
        repeat (4) @(posedge i_clk);
        #1;
    endtask

    // offer n samples back to back, recording which ones were taken
    task automatic offer(input bit is_cur, input int n, input bit corner);
        logic [5:0] code;
        logic [5:0] tgt;
        for (int i = 0; i < n; i++)
        begin
            @(posedge i_clk);
            #1;
            code = corner ? 6'h00 : 6'($urandom);
            tgt  = corner ? 6'h3F : 6'($urandom);
            if (is_cur)
                i_current_sample = '{valid: 1'b1, code: code};
            else
            begin
                i_sense_sample        = '{valid: 1'b1, code: code};
                i_target_voltage_code = tgt;
            end
            @(negedge i_clk);
            if ((is_cur ? cur_ready : sense_ready) !== 1'b1)
                refused++;
            else if (is_cur)
                cur_exp.push_back({2'b01, code});
            else
                err_exp.push_back({2'b00, 6'(code - tgt)});
        end
        @(posedge i_clk);
        #1;
        i_current_sample.valid = 1'b0;
        i_sense_sample.valid   = 1'b0;
    endtask

    task automatic drain();
        for (int w = 0; w < 600; w++)
        begin
            if (cur_got.size() >= cur_exp.size() && err_got.size() >= err_exp.size()
                && len_got.size() >= err_exp.size())
                break;
            @(posedge i_clk);
        end
        check_word("current word count", 8'(cur_exp.size()), 8'(cur_got.size()));
        check_word("error word count", 8'(err_exp.size()), 8'(err_got.size()));
        check_word("strobe count", 8'(err_exp.size()), 8'(len_got.size()));
        foreach (cur_exp[i])
            if (i < cur_got.size()) check_word("current word", cur_exp[i], cur_got[i]);
        foreach (err_exp[i])
            if (i < err_got.size()) check_word("error word", err_exp[i], err_got[i]);
        foreach (len_got[i])
            check_word("strobe length", 8'(`ERROR_WORD_BITS * `BIT_CLOCK_DIVIDE),
                       len_got[i]);
        cur_exp.delete(); err_exp.delete(); cur_got.delete(); err_got.delete(); len_got.delete();
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        power_stage_pkg::mode_t prev;
        i_clk = 1'b0; i_reset_n = 1'b0; pins = 5'h00; i_mode_code = `MODE_REGULATION;
        i_current_sample = '0; i_sense_sample = '0; i_target_voltage_code = 6'h00;
        errors = 0; n_compared = 0; cycles = 0; refused = 0;
        void'($urandom(71));
        repeat (16) @(posedge i_clk);
        #1;
        check_bit("reset high side", 1'b0, high_side);
        check_bit("reset ready", 1'b1, cur_ready);
        check_word("reset mode", 8'h00, 8'(mode));
        i_reset_n = 1'b1;
        // gate, low side and comparator flags
        for (int i = 0; i < 40; i++)
        begin
            @(posedge i_clk);
            #1;
            pins = (i < 4) ? 5'(5'h18 ^ (i << 3)) : 5'($urandom);
            settle();
            check_bit("high side", pins[4] & ~pins[3], high_side);
            check_bit("low side gate", pins[2], low_gate);
            check_bit("overshoot flag", pins[1], over_flag);
            check_bit("droop flag", pins[0], droop_flag);
        end
        $display("test pins done");
        prev = power_stage_pkg::mode_regulation;
        for (int c = 0; c < 4; c++)
        begin
            i_mode_code = 2'(c);
            settle();
            if (c < 3) prev = power_stage_pkg::mode_t'(c);
            check_word("mode", 8'(prev), 8'(mode));
        end
        i_mode_code = `MODE_REGULATION;
        settle();
        $display("test modes done");
        offer(1, 1, 1);
        offer(1, 1, 0);
        drain();
        offer(1, 6, 0);
        check_bit("current refusal seen", 1'b1, refused != 0);
        drain();
        $display("test current words done");
        refused = 0;
        offer(0, 1, 1);
        offer(0, 6, 0);
        check_bit("error refusal seen", 1'b1, refused != 0);
        drain();
        $display("test error words done");
        i_mode_code = `MODE_FAST_TRANSIENT;
        settle();
        offer(0, 2, 0);
        err_exp.delete();
        for (int i = 0; i < 40; i++)
        begin
            @(negedge i_clk);
            check_bit("strobe outside regulation", 1'b0, strobe);
        end
        $display("test strobe mode done");
        end_of_test();
    end
endmodule
